// >>> atg_regs.svh
`ifndef ATG_REGS_SVH
`define ATG_REGS_SVH

// ************************************************
// Register offsets (byte addresses, word each)
// ************************************************
`define ATG_ADDR_CTRL 8'h00
`define ATG_ADDR_DIV 8'h04
`define ATG_ADDR_POST 8'h08
`define ATG_ADDR_STATUS 8'h0C
`define ATG_ADDR_FIFO 8'h10
`define ATG_ADDR_COUNT 8'h14

// ************************************************
// Control fields
// ************************************************
`define ATG_CTRL_ENABLE 0
`define ATG_CTRL_EXT_TRIG 1
`define ATG_CTRL_TRIG_FALL 2
`define ATG_CTRL_EXT_CLK 3
`define ATG_CTRL_CLK_FALL 4
`define ATG_CTRL_GATED 5
`define ATG_CTRL_GATE_LOW 6
`define ATG_CTRL_MODE_LO 7
`define ATG_CTRL_MODE_HI 8
`define ATG_CTRL_DMA 9
`define ATG_CTRL_IE_HALF 10
`define ATG_CTRL_IE_NEMPTY 11
`define ATG_CTRL_DMA_CH_LO 12
`define ATG_CTRL_DMA_CH_HI 13
`define ATG_CTRL_DUAL 14
`define ATG_CTRL_W 15

// ************************************************
// Reset values and timing
// ************************************************
`define ATG_CTRL_RESET 15'h0000
`define ATG_DIV_RESET 24'h000032
`define ATG_POST_RESET 24'h000010
`define ATG_CLK_MHZ 50
`define ATG_FIRST_CONV_NS 400
`define ATG_START_CYCLES ((`ATG_FIRST_CONV_NS * `ATG_CLK_MHZ) / 1000)
`define ATG_ENABLE_LIMIT_NS 1000
`define ATG_HALF_LEVEL 512
`define ATG_DMA_BLOCK 65536

`endif

// >>> atg_pkg.sv
package atg_pkg;
    typedef enum logic [1:0] {
        ATG_MODE_POST,
        ATG_MODE_PRE,
        ATG_MODE_ABOUT,
        ATG_MODE_GATE
    } atg_mode_t;

    typedef enum logic [1:0] {
        ATG_DMA_CH5,
        ATG_DMA_CH6,
        ATG_DMA_CH7,
        ATG_DMA_NONE
    } atg_dma_ch_t;

    typedef enum logic [2:0] {
        ATG_IDLE,
        ATG_WAIT_TRIG,
        ATG_RUN,
        ATG_AFTER,
        ATG_DONE
    } atg_state_t;
endpackage

// >>> atg_sync_edge.sv
`timescale 1ns/1ps
`include "atg_regs.svh"

module atg_sync_edge
    import atg_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Asynchronous pin and polarity
    input wire logic pin,
    input wire logic invert,
    // Conditioned outputs
    output logic level,
    output logic active_edge
);
    typedef struct packed {
        logic meta;
        logic sync;
        logic prev;
    } atg_sync_t;

    atg_sync_t state;
    atg_sync_t next_state;

    // Only the second stage and beyond are looked at
    always_comb begin
        next_state = state;
        next_state.meta = pin;
        next_state.sync = state.meta;
        // Raw level kept, so a polarity write cannot fake an edge
        next_state.prev = state.sync;
        if (srst) begin
            next_state = '0;
        end
    end

    always_ff @(posedge clock) begin
        state <= next_state;
    end

    assign level = state.sync ^ invert;
    assign active_edge = level & ~(state.prev ^ invert);

    chk_edge_after_level: assert property (@(posedge clock) disable iff (srst)
        active_edge |-> $past(state.meta) ^ invert)
        else $error("edge without synchronised level");
endmodule

// >>> atg_sample_fifo.sv
`timescale 1ns/1ps
`include "atg_regs.svh"

module atg_sample_fifo
    import atg_pkg::*;
#(
    parameter int WIDTH = 16,
    parameter int DEPTH = 1024
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Fill side
    input wire logic push,
    input wire logic [WIDTH-1:0] push_data,
    // Drain side
    input wire logic pop,
    output logic [WIDTH-1:0] pop_data,
    // Status
    output logic empty,
    output logic full,
    output logic [$clog2(DEPTH):0] count
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] cnt;
    } atg_fifo_t;

    atg_fifo_t state;
    atg_fifo_t next_state;
    logic [WIDTH-1:0] mem [DEPTH];
    logic do_push;
    logic do_pop;

    assign do_push = push & ~full;
    assign do_pop = pop & ~empty;

    always_comb begin
        next_state = state;
        if (do_push) begin
            next_state.wr = state.wr + 1'b1;
        end
        if (do_pop) begin
            next_state.rd = state.rd + 1'b1;
        end
        next_state.cnt = state.cnt + (AW+1)'(do_push) - (AW+1)'(do_pop);
        if (srst) begin
            next_state = '0;
        end
    end

    always_ff @(posedge clock) begin
        state <= next_state;
        if (do_push) begin
            mem[state.wr] <= push_data;
        end
    end

    assign pop_data = mem[state.rd];
    assign empty = (state.cnt == '0);
    assign full = (state.cnt == (AW+1)'(DEPTH));
    assign count = state.cnt;

    chk_fifo_count: assert property (@(posedge clock) disable iff (srst)
        (do_push && !do_pop) |=> count == $past(count) + 1'b1)
        else $error("fifo count did not grow on push");
endmodule

// >>> atg_acq_control.sv
`timescale 1ns/1ps
`include "atg_regs.svh"

module atg_acq_control
    import atg_pkg::*;
#(
    parameter int SAMPLE_W = 16,
    parameter int FIFO_DEPTH = 1024
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Pins
    input wire logic trigger_gate_input,
    input wire logic external_pacer_clock_input,
    // Converter
    output logic conv_start,
    input wire logic conv_done,
    input wire logic [SAMPLE_W-1:0] conv_data,
    // Host transfer
    output logic irq,
    output logic [2:0] dma_req,
    input wire logic [2:0] dma_ack,
    output logic [SAMPLE_W-1:0] dma_data,
    // Status
    output logic overrun
);
    localparam int CW = $clog2(FIFO_DEPTH) + 1;
    localparam logic [23:0] START_CYC = 24'(`ATG_START_CYCLES);

    typedef struct packed {
        logic [`ATG_CTRL_W-1:0] ctrl;
        logic [23:0] div;
        logic [23:0] post;
        atg_state_t fsm;
        logic [23:0] pace;
        logic [23:0] remain;
        logic [31:0] taken;
        logic [16:0] block;
        logic dma_sel;
        logic ovr;
        logic [31:0] rdata;
        logic [SAMPLE_W-1:0] dout;
        logic gate_prev;
    } atg_ctl_t;

    atg_ctl_t state;
    atg_ctl_t next_state;

    logic tg_level;
    logic tg_edge;
    logic xc_edge;
    logic fifo_empty;
    logic fifo_full;
    logic [CW-1:0] fifo_count;
    logic [SAMPLE_W-1:0] fifo_head;
    logic fifo_pop;
    logic ctrl_en;
    logic ext_trig;
    logic ext_clk;
    logic gated;
    logic dma_mode;
    atg_mode_t mode;
    atg_dma_ch_t ch;
    logic half_full;
    logic gate_open;
    logic pace_tick;
    logic dma_any_ack;
    logic [2:0] dma_mask;

    // ************************************************
    // Pin conditioning
    // ************************************************
    // Same pin acts as trigger or gate; either polarity bit (ATG_CTRL_GATE_LOW or ATG_CTRL_TRIG_FALL) inverts it for both
    atg_sync_edge u_tg_sync (
        .clock(clock),
        .srst(srst),
        .pin(trigger_gate_input),
        .invert(state.ctrl[`ATG_CTRL_GATE_LOW] | state.ctrl[`ATG_CTRL_TRIG_FALL]),
        .level(tg_level),
        .active_edge(tg_edge)
    );

    atg_sync_edge u_xc_sync (
        .clock(clock),
        .srst(srst),
        .pin(external_pacer_clock_input),
        .invert(state.ctrl[`ATG_CTRL_CLK_FALL]),
        .level(),
        .active_edge(xc_edge)
    );

    atg_sample_fifo #(
        .WIDTH(SAMPLE_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clock(clock),
        .srst(srst),
        .push(conv_done),
        .push_data(conv_data),
        .pop(fifo_pop),
        .pop_data(fifo_head),
        .empty(fifo_empty),
        .full(fifo_full),
        .count(fifo_count)
    );

    // ************************************************
    // Decoded configuration
    // ************************************************
    assign ctrl_en = state.ctrl[`ATG_CTRL_ENABLE];
    assign ext_trig = state.ctrl[`ATG_CTRL_EXT_TRIG];
    assign ext_clk = state.ctrl[`ATG_CTRL_EXT_CLK];
    assign dma_mode = state.ctrl[`ATG_CTRL_DMA];
    assign mode = atg_mode_t'(state.ctrl[`ATG_CTRL_MODE_HI:`ATG_CTRL_MODE_LO]);
    assign ch = atg_dma_ch_t'(state.ctrl[`ATG_CTRL_DMA_CH_HI:`ATG_CTRL_DMA_CH_LO]);
    assign gated = (mode == ATG_MODE_GATE) | state.ctrl[`ATG_CTRL_GATED];
    assign gate_open = ~gated | tg_level;
    assign half_full = fifo_count >= CW'(`ATG_HALF_LEVEL);

    // Pacer tick from internal divider or external edge, only while gate open
    assign pace_tick = gate_open && (ext_clk ? xc_edge : (state.pace == 24'h000001));

    // ************************************************
    // DMA channel steering
    // ************************************************
    // Dual mode alternates between the chosen channel and the next one
    always_comb begin
        dma_mask = 3'h0;
        if (dma_mode && ch != ATG_DMA_NONE) begin
            dma_mask[ch] = 1'b1;
            if (state.dma_sel && state.ctrl[`ATG_CTRL_DUAL]) begin
                dma_mask = {dma_mask[1:0], dma_mask[2]};
            end
        end
    end

    assign dma_req = fifo_empty ? 3'h0 : dma_mask;
    assign dma_any_ack = |(dma_ack & dma_req);
    assign fifo_pop = dma_any_ack;
    assign dma_data = state.dout;
    assign irq = ~dma_mode & ((state.ctrl[`ATG_CTRL_IE_HALF] & half_full)
        | (state.ctrl[`ATG_CTRL_IE_NEMPTY] & ~fifo_empty));
    assign conv_start = (state.fsm == ATG_RUN || state.fsm == ATG_AFTER) && pace_tick;
    assign overrun = state.ovr;
    assign reg_rdata = state.rdata;

    // ************************************************
    // Sequencer and registers
    // ************************************************
    always_comb begin
        next_state = state;
        next_state.gate_prev = tg_level;
        next_state.rdata = 32'h0000_0000;
        if (dma_any_ack) begin
            next_state.dout = fifo_head;
            next_state.block = state.block + 17'h00001;
            // Host must reprogram a channel after a full block
            if (state.block == 17'(`ATG_DMA_BLOCK - 1)) begin
                next_state.block = 17'h00000;
                next_state.dma_sel = ~state.dma_sel;
            end
        end
        if (conv_done && fifo_full) begin
            next_state.ovr = 1'b1;
        end

        // Internal pacer: reloads on gate opening, halts while closed
        if (state.fsm == ATG_RUN || state.fsm == ATG_AFTER) begin
            if (gated && tg_level && !state.gate_prev) begin
                next_state.pace = state.div;
            end else if (gate_open && !ext_clk) begin
                next_state.pace = (state.pace == 24'h000001) ? state.div : state.pace - 24'h000001;
            end
        end

        unique case (state.fsm)
            ATG_IDLE: begin
                if (ctrl_en) begin
                    next_state.taken = 32'h0000_0000;
                    next_state.fsm = ATG_WAIT_TRIG;
                end
            end
            ATG_WAIT_TRIG: begin
                // Gated mode uses the pin as a level, not a start edge
                if (!ext_trig || gated || tg_edge) begin
                    next_state.fsm = ATG_RUN;
                    next_state.pace = START_CYC;
                end
            end
            ATG_RUN: begin
                if ((mode == ATG_MODE_PRE || mode == ATG_MODE_ABOUT) && tg_edge) begin
                    if (mode == ATG_MODE_PRE) begin
                        next_state.fsm = ATG_DONE;
                    end else begin
                        next_state.fsm = ATG_AFTER;
                        next_state.remain = state.post;
                    end
                end else if (mode == ATG_MODE_POST && conv_start && state.taken[23:0] + 24'h1 >= state.post) begin
                    next_state.fsm = ATG_DONE;
                end
            end
            ATG_AFTER: begin
                if (conv_start) begin
                    next_state.remain = state.remain - 24'h000001;
                    if (state.remain <= 24'h000001) begin
                        next_state.fsm = ATG_DONE;
                    end
                end
            end
            ATG_DONE: begin
                next_state.fsm = ATG_DONE;
            end
        endcase
        if (conv_start) begin
            next_state.taken = state.taken + 32'h0000_0001;
        end
        if (!ctrl_en) begin
            next_state.fsm = ATG_IDLE;
        end

        if (reg_wr) begin
            unique case (reg_addr)
                `ATG_ADDR_CTRL: begin
                    next_state.ctrl = reg_wdata[`ATG_CTRL_W-1:0];
                    // Pre and about need DMA; fall back to post otherwise
                    if (!reg_wdata[`ATG_CTRL_DMA] && reg_wdata[`ATG_CTRL_MODE_HI:`ATG_CTRL_MODE_LO] inside {2'h1, 2'h2}) begin
                        next_state.ctrl[`ATG_CTRL_MODE_HI:`ATG_CTRL_MODE_LO] = 2'h0;
                    end
                end
                `ATG_ADDR_DIV: next_state.div = (reg_wdata[23:0] == 24'h0) ? 24'h000001 : reg_wdata[23:0];
                `ATG_ADDR_POST: next_state.post = reg_wdata[23:0];
                `ATG_ADDR_STATUS: next_state.ovr = state.ovr & ~reg_wdata[0] | (conv_done & fifo_full);
                default: begin
                end
            endcase
        end
        if (reg_rd) begin
            unique case (reg_addr)
                `ATG_ADDR_CTRL: next_state.rdata = 32'(state.ctrl);
                `ATG_ADDR_DIV: next_state.rdata = 32'(state.div);
                `ATG_ADDR_POST: next_state.rdata = 32'(state.post);
                `ATG_ADDR_STATUS: next_state.rdata = {23'h0, 3'(state.fsm), state.dma_sel, half_full,
                    ~fifo_empty, fifo_full, irq, state.ovr};
                `ATG_ADDR_FIFO: next_state.rdata = 32'(fifo_head);
                `ATG_ADDR_COUNT: next_state.rdata = state.taken;
                default: next_state.rdata = 32'h0000_0000;
            endcase
        end

        if (srst) begin
            next_state = '0;
            next_state.ctrl = `ATG_CTRL_RESET;
            next_state.div = `ATG_DIV_RESET;
            next_state.post = `ATG_POST_RESET;
            next_state.fsm = ATG_IDLE;
        end
    end

    always_ff @(posedge clock) begin
        state <= next_state;
    end

    // ************************************************
    // Checks
    // ************************************************
    chk_first_conv_bound: assert property (@(posedge clock) disable iff (srst)
        (state.fsm == ATG_WAIT_TRIG && next_state.fsm == ATG_RUN && !ext_clk && !gated && !reg_wr)
        |-> ##[1:20] (conv_start || !ctrl_en || ext_clk || gated || state.fsm != ATG_RUN))
        else $error("first conversion late after trigger");
    chk_dma_empty_quiet: assert property (@(posedge clock) disable iff (srst)
        fifo_empty |-> dma_req == 3'h0)
        else $error("dma request with empty fifo");
    chk_irq_half: assert property (@(posedge clock) disable iff (srst)
        (!dma_mode && state.ctrl[`ATG_CTRL_IE_HALF] && fifo_count >= CW'(`ATG_HALF_LEVEL)) |-> irq)
        else $error("half full interrupt missing");
    chk_irq_nempty: assert property (@(posedge clock) disable iff (srst)
        (!dma_mode && state.ctrl[`ATG_CTRL_IE_NEMPTY] && !fifo_empty) |-> irq)
        else $error("not empty interrupt missing");
    chk_gate_blocks: assert property (@(posedge clock) disable iff (srst)
        (gated && !tg_level) |-> !conv_start)
        else $error("conversion while gate inactive");
    chk_ext_clk_only: assert property (@(posedge clock) disable iff (srst)
        (ext_clk && conv_start) |-> xc_edge)
        else $error("external conversion without clock edge");
    chk_gate_reload: assert property (@(posedge clock) disable iff (srst)
        (state.fsm == ATG_RUN && gated && tg_level && !state.gate_prev && !reg_wr && ctrl_en)
        |=> state.pace == $past(state.div))
        else $error("pacer not reloaded on gate");
    chk_about_stop: assert property (@(posedge clock) disable iff (srst)
        (state.fsm == ATG_AFTER && conv_start && state.remain == 24'h1 && ctrl_en && !reg_wr)
        |=> state.fsm == ATG_DONE)
        else $error("about trigger did not stop");
    chk_int_start: assert property (@(posedge clock) disable iff (srst)
        (state.fsm == ATG_WAIT_TRIG && !ext_trig && ctrl_en && !reg_wr) |=> state.fsm == ATG_RUN)
        else $error("internal start did not begin");
    chk_enable_start: assert property (@(posedge clock) disable iff (srst)
        (state.fsm == ATG_IDLE && ctrl_en && !reg_wr) |=> state.fsm == ATG_WAIT_TRIG)
        else $error("enable not taken");
endmodule

// >>> atg_partner.sv
`timescale 1ns/1ps

// ************************************************
// Converter and host transfer model
// ************************************************
module atg_partner (
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Converter side
    input wire logic conv_start,
    output logic conv_done,
    output logic [15:0] conv_data,
    // Host transfer side
    input wire logic [2:0] dma_req,
    input wire logic ack_en,
    output logic [2:0] dma_ack
);
    logic busy;
    logic slow;
    logic [1:0] wait_cnt;
    logic [15:0] seq;

    // Alternates short and long conversions; data toggles when not valid
    always_ff @(posedge clock) begin
        if (srst) begin
            conv_done <= 1'b0;
            conv_data <= 16'h0000;
            busy <= 1'b0;
            slow <= 1'b0;
            wait_cnt <= 2'h0;
            seq <= 16'hA000;
            dma_ack <= 3'h0;
        end else begin
            conv_done <= 1'b0;
            conv_data <= ~conv_data;
            if (conv_start) begin
                busy <= 1'b1;
                wait_cnt <= slow ? 2'h2 : 2'h1;
                slow <= ~slow;
            end else if (busy && wait_cnt == 2'h0) begin
                busy <= 1'b0;
                conv_done <= 1'b1;
                conv_data <= seq + 16'h0001;
                seq <= seq + 16'h0001;
            end else if (busy) begin
                wait_cnt <= wait_cnt - 2'h1;
            end
            // One ack per request, then an idle cycle to see the request drop
            if (ack_en && dma_ack == 3'h0) begin
                dma_ack <= dma_req;
            end else begin
                dma_ack <= 3'h0;
            end
        end
    end
endmodule

// >>> tb_acquisition_trigger_gate_control.sv
`timescale 1ns/1ps
`include "atg_regs.svh"

module tb_acquisition_trigger_gate_control;
    import atg_pkg::*;
    typedef struct packed {logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] e;} atg_row_t;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic tg = 1'b0;
    logic xclk = 1'b0;
    logic conv_start, conv_done, irq, overrun, ack_en = 1'b0;
    logic [15:0] conv_data, dma_data;
    logic [2:0] dma_req, dma_ack, seen_req = 3'h0;
    logic [31:0] q;
    int errors = 0;
    int check_count = 0;
    int cycles = 0;
    int n_conv = 0;
    int n0, lat;
    atg_row_t rows [10] = '{
        '{1'b0, `ATG_ADDR_CTRL, 32'h0, 32'h0}, '{1'b0, `ATG_ADDR_DIV, 32'h0, 32'h32},
        '{1'b0, `ATG_ADDR_POST, 32'h0, 32'h10}, '{1'b0, 8'h18, 32'h0, 32'h0},
        '{1'b1, 8'h18, 32'hFFFF, 32'h0}, '{1'b1, `ATG_ADDR_DIV, 32'h4, 32'h4},
        '{1'b1, `ATG_ADDR_POST, 32'h3, 32'h3}, '{1'b1, `ATG_ADDR_CTRL, 32'h80, 32'h0},
        '{1'b1, `ATG_ADDR_CTRL, 32'h300, 32'h300}, '{1'b1, `ATG_ADDR_CTRL, 32'h100, 32'h0}};

    always #10 clock = ~clock;

    atg_acq_control dut (.clock(clock), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .trigger_gate_input(tg),
        .external_pacer_clock_input(xclk), .conv_start(conv_start), .conv_done(conv_done),
        .conv_data(conv_data), .irq(irq), .dma_req(dma_req), .dma_ack(dma_ack),
        .dma_data(dma_data), .overrun(overrun));

    atg_partner far_side (.clock(clock), .srst(srst), .conv_start(conv_start), .conv_done(conv_done),
        .conv_data(conv_data), .dma_req(dma_req), .ack_en(ack_en), .dma_ack(dma_ack));

    // ************************************************
    // Monitors and timeout
    // ************************************************
    always @(posedge clock) begin
        cycles++;
        if (conv_start === 1'b1) n_conv++;
        seen_req <= seen_req | dma_req;
        if (cycles == 20000) begin
            errors++;
            conclude();
        end
    end

    // ************************************************
    // Tasks
    // ************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 q = reg_rdata;
    endtask

    // Marks the conversion count, then lets n cycles pass
    task automatic idle(input int n);
        n0 = n_conv;
        repeat (n) @(posedge clock);
        #1;
    endtask

    // Cycles until the next conversion start, capped
    task automatic wait_conv();
        n0 = n_conv;
        lat = 0;
        while (n_conv == n0 && lat < 200) begin
            @(posedge clock);
            #1 lat++;
        end
    endtask

    task automatic pulse_x();
        repeat (5) @(posedge clock);
        xclk <= 1'b1;
        repeat (5) @(posedge clock);
        xclk <= 1'b0;
    endtask

    task automatic conclude();
        if (errors == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // ************************************************
    // Main sequence
    // ************************************************
    initial begin
        repeat (4) @(posedge clock);
        srst <= 1'b0;
        foreach (rows[i]) begin
            if (rows[i].wr) wr(rows[i].a, rows[i].d);
            rd(rows[i].a);
            check(q, rows[i].e);
        end
        // Internal start, internal pacer, post mode, not-empty interrupt
        wr(`ATG_ADDR_CTRL, 32'h801);
        wait_conv();
        check(32'(lat <= 25), 32'h1);
        idle(60);
        check(32'(n_conv - n0 + 1), 32'h3);
        check({31'h0, irq}, 32'h1);
        rd(`ATG_ADDR_STATUS);
        check(q, 32'h10A);
        rd(`ATG_ADDR_FIFO);
        check(q, 32'hA001);
        // Same run moved by DMA on the second channel
        wr(`ATG_ADDR_CTRL, 32'h0);
        ack_en <= 1'b1;
        wr(`ATG_ADDR_CTRL, 32'h1201);
        idle(100);
        check({29'h0, seen_req}, 32'h2);
        check({29'h0, dma_req}, 32'h0);
        check({16'h0, dma_data}, 32'hA006);
        check({31'h0, irq}, 32'h0);
        check({31'h0, overrun}, 32'h0);
        // External start on the falling edge only
        wr(`ATG_ADDR_CTRL, 32'h0);
        wr(`ATG_ADDR_CTRL, 32'h7);
        @(posedge clock);
        tg <= 1'b1;
        idle(40);
        idle(40);
        check(32'(n_conv - n0), 32'h0);
        @(posedge clock);
        tg <= 1'b0;
        wait_conv();
        check(32'(lat <= 25), 32'h1);
        // External pacer, falling edge active: armed until the edges come
        wr(`ATG_ADDR_CTRL, 32'h0);
        wr(`ATG_ADDR_CTRL, 32'h19);
        idle(40);
        check(32'(n_conv - n0), 32'h0);
        pulse_x();
        pulse_x();
        repeat (10) @(posedge clock);
        #1 check(32'(n_conv - n0), 32'h2);
        pulse_x();
        pulse_x();
        repeat (10) @(posedge clock);
        #1 check(32'(n_conv - n0), 32'h3);
        // Gated, active high, internal pacer
        wr(`ATG_ADDR_CTRL, 32'h0);
        wr(`ATG_ADDR_CTRL, 32'h1A1);
        idle(40);
        check(32'(n_conv - n0), 32'h0);
        @(posedge clock);
        tg <= 1'b1;
        wait_conv();
        check(32'(lat <= 25), 32'h1);
        @(posedge clock);
        tg <= 1'b0;
        idle(10);
        idle(40);
        check(32'(n_conv - n0), 32'h0);
        // About trigger: exactly the programmed samples after the pin edge
        wr(`ATG_ADDR_CTRL, 32'h0);
        wr(`ATG_ADDR_CTRL, 32'h1301);
        idle(40);
        @(posedge clock);
        tg <= 1'b1;
        idle(3);
        idle(40);
        check(32'(n_conv - n0), 32'h3);
        rd(`ATG_ADDR_STATUS);
        check(q & 32'h1C0, 32'h100);
        // Pre-trigger: the pin edge ends sampling at once
        @(posedge clock);
        tg <= 1'b0;
        wr(`ATG_ADDR_CTRL, 32'h0);
        wr(`ATG_ADDR_CTRL, 32'h1281);
        idle(40);
        check(32'(n_conv - n0 > 0), 32'h1);
        @(posedge clock);
        tg <= 1'b1;
        idle(3);
        idle(40);
        check(32'(n_conv - n0), 32'h0);
        rd(`ATG_ADDR_STATUS);
        check(q & 32'h1C0, 32'h100);
        // Reset after the run has stopped in ATG_DONE restores defaults
        @(posedge clock);
        srst <= 1'b1;
        idle(2);
        srst <= 1'b0;
        check({29'h0, dma_req}, 32'h0);
        rd(`ATG_ADDR_DIV);
        check(q, 32'h32);
        conclude();
    end
endmodule
